// [rtl/gpdp_params.svh]
// Function
// [R1] Address from switch bits one to five
// [R2] Switch down reads zero, up reads one
// [R3] Bit six picks comma or CR LF
// [R4] Bit seven enables EOI at transfer end
// [R5] Switches captured at power-on and reported
// [R6] Drive SRQ, listen, talk, remote indicators
// [R7] Local key returns device to local
// [R8] Lockout makes local key ignored
// [R9] Overlay graphics mode forces local lockout
// [R10] No controller means talk-only source
// [R11] Talker unaddresses when addressed to listen
// [R12] Listener unaddresses when addressed to talk
// [R13] Remote/local with local lockout
// [R14] Service request, clear, trigger, end message
// [R15] Switches synchronised and held after reset
`ifndef GPDP_PARAMS_SVH
`define GPDP_PARAMS_SVH
// APB register byte offsets
`define GPDP_OFF_CFG 12'h000
`define GPDP_OFF_STAT 12'h004
`define GPDP_OFF_CTRL 12'h008
`define GPDP_OFF_IRQ 12'h00c
`define GPDP_OFF_MASK 12'h010
`define GPDP_OFF_DATA 12'h014
// Switch field positions
`define GPDP_SW_ADDR_LSB 0
`define GPDP_SW_DELIM_BIT 5
`define GPDP_SW_EOI_BIT 6
// Highest legal bus address
`define GPDP_ADDR_MAX 5'h1e
// Cycles the switch sync runs before capture
`define GPDP_CAPTURE_CYC 4'h4
// Control register bits
`define GPDP_CTRL_SRQ 0
`define GPDP_CTRL_TON 1
// Event bit positions
`define GPDP_EV_CLR 0
`define GPDP_EV_TRG 1
`define GPDP_EV_LOC 2
`define GPDP_EV_SENT 3
`define GPDP_EV_W 4
`endif

// [rtl/gpdp_pkg.sv]
package gpdp_pkg;
	// Remote/local states
	typedef enum logic [1:0] {
		GPDP_LOCS = 2'b00,
		GPDP_REMS = 2'b01,
		GPDP_LWLS = 2'b10,
		GPDP_RWLS = 2'b11
	} gpdp_rl_type;
	// Output delimiter character steps
	typedef enum logic [1:0] {
		GPDP_TX_IDLE = 2'b00,
		GPDP_TX_DATA = 2'b01,
		GPDP_TX_CR = 2'b10,
		GPDP_TX_LF = 2'b11
	} gpdp_tx_type;
endpackage : gpdp_pkg

// [rtl/gpdp_port.sv]
`timescale 1ns/1ps
`default_nettype none
`include "gpdp_params.svh"
module gpdp_port (
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Rear switch, down is zero, up is one
	input wire logic [6:0] cfg_switch,
	// Decoded bus messages from the bus transceiver
	input wire logic ctrl_present,
	input wire logic ren,
	input wire logic my_listen_addr,
	input wire logic my_talk_addr,
	input wire logic unlisten,
	input wire logic untalk,
	input wire logic ifc,
	input wire logic llo_cmd,
	input wire logic gtl_cmd,
	input wire logic dcl_cmd,
	input wire logic get_cmd,
	input wire logic spoll_active,
	input wire logic local_key,
	input wire logic overlay_graphics_mode,
	// Byte source handshake toward the bus
	input wire logic tx_ready,
	output logic tx_valid,
	output logic [7:0] tx_byte,
	output logic tx_eoi,
	// Status indicators
	output logic srq_led,
	output logic listen_led,
	output logic talk_led,
	output logic remote_led,
	output logic lockout,
	output logic [4:0] bus_addr,
	output logic irq
);
	// Captured switch set and its valid flag
	logic [6:0] sw_cfg;
	logic cfg_valid;
	// Remote/local results
	logic remote;
	logic local_ev;
	// Addressed states
	logic lads_q;
	logic tads_q;
	logic talk_only;
	// Software control and interrupt registers
	logic [1:0] ctrl_q;
	logic [3:0] irq_q;
	logic [3:0] mask_q;
	logic [3:0] ev;
	// Output data item and its pending flag
	logic [7:0] item_q;
	logic item_last_q;
	logic item_pend_q;
	gpdp_pkg::gpdp_tx_type tx_q;
	logic [31:0] rd_d;
	logic wr_acc;
	logic rd_acc;
	logic addr_ok;
	logic delim_crlf;
	logic eoi_en;
	logic sent;

	////////////////////////////////////////////////////////////
	// [R5] power-on switch capture
	gpdp_sw_capture u_cap (
		.pclk(pclk),
		.presetn(presetn),
		.sw_raw(cfg_switch),
		.sw_cfg(sw_cfg),
		.cfg_valid(cfg_valid)
	);

	// [R1] five bit address
	assign bus_addr = sw_cfg[`GPDP_SW_ADDR_LSB +: 5];
	// Address 31 is illegal; the port then is never addressed to listen or talk, but talk only still sends
	assign addr_ok = cfg_valid && (bus_addr <= `GPDP_ADDR_MAX);
	// [R3] delimiter select
	assign delim_crlf = sw_cfg[`GPDP_SW_DELIM_BIT];
	// [R4] EOI select
	assign eoi_en = sw_cfg[`GPDP_SW_EOI_BIT];
	// [R10] talk only without controller
	assign talk_only = cfg_valid && !ctrl_present;

	// Remote enable only counts while a controller is on the bus
	gpdp_remote_local u_rl (
		.pclk(pclk),
		.presetn(presetn),
		.ren(ren & ctrl_present),
		.go_remote(my_listen_addr & addr_ok),
		.go_local_cmd(gtl_cmd & lads_q),
		.llo_cmd(llo_cmd),
		.local_key(local_key),
		.overlay_graphics_mode(overlay_graphics_mode),
		.remote(remote),
		.lockout(lockout),
		.local_ev(local_ev)
	);

	////////////////////////////////////////////////////////////
	// Listener state
	// Interface clear, unlisten or an illegal address drop it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lads_q <= 1'b0;
		end else if (ifc || unlisten || !addr_ok) begin
			lads_q <= 1'b0;
		end else if (my_listen_addr) begin
			lads_q <= 1'b1;
		// [R12] addressed to talk leaves listen
		end else if (my_talk_addr) begin
			lads_q <= 1'b0;
		end
	end

	// Talker state
	// Interface clear, untalk or an illegal address drop it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tads_q <= 1'b0;
		end else if (ifc || untalk || !addr_ok) begin
			tads_q <= 1'b0;
		end else if (my_talk_addr) begin
			tads_q <= 1'b1;
		// [R11] addressed to listen leaves talk
		end else if (my_listen_addr) begin
			tads_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////
	// APB decode; zero wait states
	// Every register answers in the access cycle, so pready never drops
	// Read data is latched in setup; the access phase only confirms it
	assign wr_acc = psel & penable & pwrite;
	assign rd_acc = psel & penable & ~pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;

	// Control register: SRQ request and talk enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= 2'h0;
		end else if (wr_acc && paddr == `GPDP_OFF_CTRL) begin
			ctrl_q <= pwdata[1:0];
		end
	end

	// Interrupt mask, same bit layout as the status
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_q <= 4'h0;
		end else if (wr_acc && paddr == `GPDP_OFF_MASK) begin
			mask_q <= pwdata[3:0];
		end
	end

	////////////////////////////////////////////////////////////
	// [R14] clear, trigger, local, sent events
	// One process drives the whole vector, so no bit has two drivers
	always_comb begin
		ev = 4'h0;
		ev[`GPDP_EV_CLR] = dcl_cmd;
		// Trigger only counts while addressed to listen
		ev[`GPDP_EV_TRG] = get_cmd & lads_q;
		ev[`GPDP_EV_LOC] = local_ev;
		ev[`GPDP_EV_SENT] = sent;
	end

	// Sticky status, write one clears; a new event wins the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_q <= 4'h0;
		end else if (wr_acc && paddr == `GPDP_OFF_IRQ) begin
			irq_q <= (irq_q & ~pwdata[3:0]) | ev;
		end else begin
			irq_q <= irq_q | ev;
		end
	end
	assign irq = |(irq_q & mask_q);

	////////////////////////////////////////////////////////////
	// Last byte of the delimiter leaves at this edge
	logic tx_done;
	assign tx_done = tx_ready && (tx_q == gpdp_pkg::GPDP_TX_LF || (tx_q == gpdp_pkg::GPDP_TX_CR && !delim_crlf));

	// Right to send: addressed to talk, or talk only and enabled
	logic may_talk;
	assign may_talk = tads_q || (talk_only && ctrl_q[`GPDP_CTRL_TON]);

	// Data item loaded by software, one byte at a time
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			item_q <= 8'h00;
			item_last_q <= 1'b0;
			item_pend_q <= 1'b0;
		end else if (wr_acc && paddr == `GPDP_OFF_DATA && !item_pend_q) begin
			item_q <= pwdata[7:0];
			item_last_q <= pwdata[8];
			item_pend_q <= 1'b1;
		end else if (tx_q == gpdp_pkg::GPDP_TX_IDLE && item_pend_q && dcl_cmd) begin
			// Device clear drops an item that has not started
			item_pend_q <= 1'b0;
		end else if (tx_done) begin
			// Pending until the delimiter has left, so a new write cannot alter an item in flight
			item_pend_q <= 1'b0;
		end
	end

	// [R3] delimiter sequencer after each item
	// [R10] talk only sends unaddressed
	// A device clear in the same cycle wins over starting a send
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_q <= gpdp_pkg::GPDP_TX_IDLE;
		end else begin
			case (tx_q)
				gpdp_pkg::GPDP_TX_IDLE: begin
					// Wait for an item and the right to talk
					if (item_pend_q && !dcl_cmd && may_talk && !spoll_active) begin
						tx_q <= gpdp_pkg::GPDP_TX_DATA;
					end
				end
				gpdp_pkg::GPDP_TX_DATA: begin
					// Item byte first
					if (tx_ready) begin
						tx_q <= gpdp_pkg::GPDP_TX_CR;
					end
				end
				gpdp_pkg::GPDP_TX_CR: begin
					// Comma or CR; a CR LF delimiter always goes on to LF
					if (tx_ready) begin
						tx_q <= delim_crlf ? gpdp_pkg::GPDP_TX_LF : gpdp_pkg::GPDP_TX_IDLE;
					end
				end
				gpdp_pkg::GPDP_TX_LF: begin
					// LF closes the CR LF delimiter
					if (tx_ready) begin
						tx_q <= gpdp_pkg::GPDP_TX_IDLE;
					end
				end
				default: begin
					tx_q <= gpdp_pkg::GPDP_TX_IDLE;
				end
			endcase
		end
	end

	// Delimiter byte: comma, or CR then LF; a last item with comma setting ends on a lone CR
	always_comb begin
		tx_valid = (tx_q != gpdp_pkg::GPDP_TX_IDLE);
		tx_byte = item_q;
		tx_eoi = 1'b0;
		if (tx_q == gpdp_pkg::GPDP_TX_CR) begin
			tx_byte = (delim_crlf || item_last_q) ? 8'h0d : 8'h2c;
			// [R4] EOI on final byte
			tx_eoi = eoi_en && item_last_q && !delim_crlf;
		end else if (tx_q == gpdp_pkg::GPDP_TX_LF) begin
			tx_byte = 8'h0a;
			tx_eoi = eoi_en && item_last_q;
		end
	end
	assign sent = tx_ready && tx_eoi;

	////////////////////////////////////////////////////////////
	// [R6] status indicators
	assign srq_led = ctrl_q[`GPDP_CTRL_SRQ];
	assign listen_led = lads_q;
	assign talk_led = tads_q | (talk_only & ctrl_q[`GPDP_CTRL_TON]);
	// [R7] remote indicator clears on local
	assign remote_led = remote;

	// Read mux; unmapped reads return zero
	// Reads have no side effect, so early latching in setup is safe
	always_comb begin
		rd_d = 32'h00000000;
		case (paddr)
			// [R2] raw levels as captured
			`GPDP_OFF_CFG: rd_d = {24'h000000, cfg_valid, sw_cfg};
			`GPDP_OFF_STAT: rd_d = {26'h0000000, lockout, remote, talk_led, listen_led, srq_led, item_pend_q};
			`GPDP_OFF_CTRL: rd_d = {30'h00000000, ctrl_q};
			`GPDP_OFF_IRQ: rd_d = {28'h0000000, irq_q};
			`GPDP_OFF_MASK: rd_d = {28'h0000000, mask_q};
			default: rd_d = 32'h00000000;
		endcase
	end

	// Registered read data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= rd_d;
		end
	end
	// Access strobe for reads is not needed beyond decode
	logic unused_rd;
	assign unused_rd = rd_acc;
endmodule : gpdp_port
`default_nettype wire

// [rtl/gpdp_remote_local.sv]
`timescale 1ns/1ps
`default_nettype none
`include "gpdp_params.svh"
module gpdp_remote_local (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ren,
	input wire logic go_remote,
	input wire logic go_local_cmd,
	input wire logic llo_cmd,
	input wire logic local_key,
	input wire logic overlay_graphics_mode,
	output logic remote,
	output logic lockout,
	output logic local_ev
);
	// Current remote/local state
	gpdp_pkg::gpdp_rl_type st_q;
	logic lock_eff;
	// [R9] overlay forces lockout
	assign lock_eff = st_q[1] | overlay_graphics_mode;

	////////////////////////////////////////////////////////////
	// [R13] remote local machine
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= gpdp_pkg::GPDP_LOCS;
		end else if (!ren) begin
			// Dropping remote enable always returns to local
			st_q <= gpdp_pkg::GPDP_LOCS;
		end else begin
			case (st_q)
				gpdp_pkg::GPDP_LOCS: begin
					if (go_remote) begin
						st_q <= llo_cmd ? gpdp_pkg::GPDP_RWLS : gpdp_pkg::GPDP_REMS;
					end else if (llo_cmd) begin
						st_q <= gpdp_pkg::GPDP_LWLS;
					end
				end
				gpdp_pkg::GPDP_REMS: begin
					// [R7] local key releases remote
					if (local_key && !overlay_graphics_mode) begin
						st_q <= gpdp_pkg::GPDP_LOCS;
					end else if (go_local_cmd) begin
						st_q <= gpdp_pkg::GPDP_LOCS;
					end else if (llo_cmd || overlay_graphics_mode) begin
						st_q <= gpdp_pkg::GPDP_RWLS;
					end
				end
				gpdp_pkg::GPDP_LWLS: begin
					if (go_remote) begin
						st_q <= gpdp_pkg::GPDP_RWLS;
					end
				end
				gpdp_pkg::GPDP_RWLS: begin
					// [R8] key ignored under lockout
					if (go_local_cmd) begin
						st_q <= gpdp_pkg::GPDP_LWLS;
					end
				end
				default: begin
					st_q <= gpdp_pkg::GPDP_LOCS;
				end
			endcase
		end
	end

	// Key press while remote and unlocked gives an event
	assign local_ev = local_key & (st_q == gpdp_pkg::GPDP_REMS) & ~overlay_graphics_mode;
	assign remote = st_q[0];
	assign lockout = lock_eff;
endmodule : gpdp_remote_local
`default_nettype wire

// [rtl/gpdp_sw_capture.sv]
`timescale 1ns/1ps
`default_nettype none
`include "gpdp_params.svh"
module gpdp_sw_capture (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [6:0] sw_raw,
	output logic [6:0] sw_cfg,
	output logic cfg_valid
);
	// Synchroniser stages; first stage feeds only the second
	logic [6:0] s1_q;
	logic [6:0] s2_q;
	// Settle counter before capture
	logic [3:0] cnt_q;

	////////////////////////////////////////////////////////////
	// [R15] sync switch bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q <= 7'h00;
			s2_q <= 7'h00;
		end else begin
			s1_q <= sw_raw;
			s2_q <= s1_q;
		end
	end

	// Count settle cycles after reset release
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 4'h0;
		end else if (cnt_q != `GPDP_CAPTURE_CYC) begin
			cnt_q <= cnt_q + 4'h1;
		end
	end

	// [R5] capture once at power-on
	// Held afterwards so a moved switch cannot upset a transfer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sw_cfg <= 7'h00;
			cfg_valid <= 1'b0;
		end else if (!cfg_valid && cnt_q == `GPDP_CAPTURE_CYC) begin
			sw_cfg <= s2_q;
			cfg_valid <= 1'b1;
		end
	end
endmodule : gpdp_sw_capture
`default_nettype wire

// [testbench/gpdp_bus_model.sv]
`timescale 1ns/1ps
`default_nettype none
module gpdp_bus_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic slow,
	input wire logic tx_valid,
	input wire logic [7:0] tx_byte,
	input wire logic tx_eoi,
	output logic tx_ready
);
	// Every byte taken, end flag on top
	logic [8:0] got[$];
	// acceptor handshake, paced
	// Slow mode stalls every other cycle to stress the source side
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_ready <= 1'b0;
		end else begin
			tx_ready <= slow ? ~tx_ready : 1'b1;
			if (tx_valid && tx_ready) begin
				got.push_back({tx_eoi, tx_byte});
			end
		end
	end
endmodule : gpdp_bus_model
`default_nettype wire

// [testbench/gpdp_port_props.sv]
`timescale 1ns/1ps
`default_nettype none
module gpdp_port_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [6:0] cfg_switch,
	input wire logic ren,
	input wire logic my_listen_addr,
	input wire logic my_talk_addr,
	input wire logic local_key,
	input wire logic overlay_graphics_mode,
	input wire logic tx_ready,
	input wire logic tx_valid,
	input wire logic tx_eoi,
	input wire logic [7:0] tx_byte,
	input wire logic talk_led,
	input wire logic listen_led,
	input wire logic remote_led,
	input wire logic lockout,
	input wire logic [4:0] bus_addr
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Edges since reset release; saturates so late checks stay armed
	logic [3:0] cnt_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 4'h0;
		end else if (cnt_q != 4'hf) begin
			cnt_q <= cnt_q + 4'h1;
		end
	end
	////////////////////////////////
	a_addr_capture: assert property (cnt_q == 4'ha |-> bus_addr == cfg_switch[4:0])
		else $error("bus address differs from switch");
	a_addr_held: assert property (cnt_q == 4'hf |-> $stable(bus_addr))
		else $error("bus address moved after capture");
	a_overlay_lock: assert property (overlay_graphics_mode [*2] |-> lockout)
		else $error("overlay mode without lockout");
	a_lock_holds: assert property (ren && lockout && remote_led && local_key |=> remote_led)
		else $error("local key obeyed under lockout");
	a_local_key: assert property (cnt_q == 4'hf && ren && remote_led && local_key && !lockout
		&& !overlay_graphics_mode |-> ##[1:2] !remote_led) else $error("local key ignored");
	a_listen_untalk: assert property (cnt_q == 4'hf && my_listen_addr && !my_talk_addr |-> ##[1:2] !talk_led)
		else $error("talker kept when addressed to listen");
	a_talk_unlisten: assert property (cnt_q == 4'hf && my_talk_addr && !my_listen_addr |-> ##[1:2] !listen_led)
		else $error("listener kept when addressed to talk");
	a_ren_drop: assert property ($fell(ren) |-> ##[1:2] !remote_led)
		else $error("remote kept after enable fell");
	a_eoi_framed: assert property (tx_eoi |-> tx_valid && (tx_byte == 8'h0a || tx_byte == 8'h0d))
		else $error("end flag without closing byte");
	// Main scenarios reached
	c_local: cover property (local_key && remote_led && !lockout);
	c_overlay: cover property (overlay_graphics_mode && lockout);
	c_eoi: cover property (tx_valid && tx_ready && tx_eoi);
endmodule : gpdp_port_props
bind gpdp_port gpdp_port_props u_gpdp_port_props (.pclk, .presetn, .cfg_switch, .ren, .my_listen_addr,
	.my_talk_addr, .local_key, .overlay_graphics_mode, .tx_ready, .tx_valid, .tx_eoi, .tx_byte, .talk_led,
	.listen_led, .remote_led, .lockout, .bus_addr);
`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	// Bus master, reset and level inputs
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0;
	logic ctrl_present = 0, ren = 0, overlay_graphics_mode = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic [6:0] cfg_switch = 7'h00;
	// Pulsed messages: listen, talk, lockout, local key, clear, trigger, go to local
	logic [6:0] pls = 7'h00;
	logic pready, pslverr, tx_valid, tx_ready, tx_eoi, srq_led, listen_led, talk_led, remote_led, lockout, irq;
	logic [7:0] tx_byte;
	logic [4:0] bus_addr;
	int mismatches = 0, n_compared = 0;
	// Rows: switch setting beside the address it must give
	logic [11:0] rows [4] = '{{7'h00, 5'h00}, {7'h1e, 5'h1e}, {7'h55, 5'h15}, {7'h2a, 5'h0a}};
	gpdp_port u_gpdp_port (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .cfg_switch, .ctrl_present, .ren, .my_listen_addr(pls[0]), .my_talk_addr(pls[1]),
		.unlisten(1'b0), .untalk(1'b0), .ifc(1'b0), .llo_cmd(pls[2]), .gtl_cmd(pls[6]), .dcl_cmd(pls[4]),
		.get_cmd(pls[5]), .spoll_active(1'b0), .local_key(pls[3]), .overlay_graphics_mode, .tx_ready,
		.tx_valid, .tx_byte, .tx_eoi, .srq_led, .listen_led, .talk_led, .remote_led, .lockout, .bus_addr, .irq);
	gpdp_bus_model u_gpdp_bus_model (.pclk, .presetn, .slow, .tx_valid, .tx_byte, .tx_eoi, .tx_ready);
	initial begin
		forever #2.5 pclk = ~pclk;
	end
	////////////////////////////////
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		n_compared++;
		if (s !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : close_out
	// One APB transfer; waits on pready, read data lands in r
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic rst();
		presetn <= 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		repeat (10) @(posedge pclk);
	endtask : rst
	task automatic pulse(input int b);
		pls[b] <= 1'b1;
		@(posedge pclk);
		pls[b] <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask : pulse
	// Talk-only send of one item; e holds expected bytes, first in the low bits
	task automatic snd(input logic [6:0] s, input logic [31:0] d, input logic [26:0] e, input int n);
		cfg_switch <= s;
		rst();
		u_gpdp_bus_model.got.delete();
		apb(1'b1, 12'h010, 32'h8);
		apb(1'b1, 12'h008, 32'h2);
		apb(1'b1, 12'h014, d);
		repeat (40) @(posedge pclk);
		chk("bytes", n, u_gpdp_bus_model.got.size());
		for (int i = 0; i < n; i++) chk("byte", e[i*9+:9], u_gpdp_bus_model.got[i]);
		// End message sent only with EOI switch up on a last item
		chk("irq", {31'h0, s[6] & d[8]}, irq);
		apb(1'b1, 12'h00c, 32'h8);
		chk("irq_clr", 0, irq);
		$display("send test done");
	endtask : snd
	// Watchdog: the whole run needs well under 2000 cycles
	initial begin
		repeat (5000) @(posedge pclk);
		mismatches++;
		close_out();
	end
	initial begin
		for (int i = 0; i < 4; i++) begin
			cfg_switch <= rows[i][11:5];
			rst();
			chk("bus_addr", rows[i][4:0], bus_addr);
			apb(1'b0, 12'h000, 32'h0);
			chk("cfg", {24'h0, 1'b1, rows[i][11:5]}, r);
			cfg_switch <= ~rows[i][11:5];
			repeat (8) @(posedge pclk);
			chk("addr_hold", rows[i][4:0], bus_addr);
			$display("row %0d done", i);
		end
		snd(7'h61, 32'h141, {9'h10a, 9'h00d, 9'h041}, 3);
		slow <= 1'b1;
		snd(7'h01, 32'h042, {9'h000, 9'h02c, 9'h042}, 2);
		ctrl_present <= 1'b1;
		ren <= 1'b1;
		rst();
		pulse(4);
		// Trigger counts only while listening, so address first
		pulse(0);
		pulse(5);
		chk("listen", 1, listen_led);
		chk("remote", 1, remote_led);
		pulse(1);
		chk("listen_off", 0, listen_led);
		chk("talk", 1, talk_led);
		pulse(0);
		chk("talk_off", 0, talk_led);
		pulse(3);
		chk("local", 0, remote_led);
		apb(1'b0, 12'h00c, 32'h0);
		chk("events", 32'h7, r);
		pulse(0);
		pulse(2);
		pulse(3);
		chk("locked", 1, remote_led);
		pulse(6);
		chk("gtl", 0, remote_led);
		chk("gtl_lock", 1, lockout);
		pulse(0);
		chk("relock", 1, remote_led);
		ren <= 1'b0;
		repeat (3) @(posedge pclk);
		chk("ren_off", 0, remote_led);
		overlay_graphics_mode <= 1'b1;
		repeat (3) @(posedge pclk);
		chk("overlay", 1, lockout);
		apb(1'b1, 12'h008, 32'h1);
		chk("srq", 1, srq_led);
		$display("remote test done");
		close_out();
	end
endmodule : tb_top
`default_nettype wire
